// [src/tec_top.sv]
// dual 8-bit timer/event counter with mode, compare, clock select and
// shared-pin direction registers on a byte-wide peripheral port.
// assumes ref_clk is the peripheral clock and the pins are asynchronous.
`include "tec_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tec_top #(
  parameter int unsigned PRESCALE_W   = 13,             // widest divide exponent
  parameter int unsigned CH0_SLOW_EXP = `TEC_CH0_EXP7,  // slowest channel 0 divide
  parameter int unsigned CH1_SLOW_EXP = `TEC_CH1_EXP7   // slowest channel 1 divide
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // register port
  input  wire tec_pkg::tec_addr_t reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire tec_pkg::tec_byte_t reg_wdata,
  output tec_pkg::tec_byte_t     reg_rdata,
  output logic                   reg_rvalid,
  // shared timer pins, index is the channel
  input  wire logic [1:0]        timer_pin_in,
  output logic [1:0]             timer_pin_out,
  output logic [1:0]             timer_pin_oe_n,
  // other port pins' direction
  output logic [7:0]             port1_dir_out,
  output logic [3:0]             port3_dir_out,
  // compare match requests
  output logic [1:0]             match_irq
);
  import tec_pkg::*;

  // per-channel register addresses
  localparam tec_addr_t MODE_ADDR [2] = '{`TEC_ADDR_MODE0, `TEC_ADDR_MODE1};
  localparam tec_addr_t SEL_ADDR  [2] = '{`TEC_ADDR_CLKSEL0, `TEC_ADDR_CLKSEL1};
  localparam tec_addr_t CMP_ADDR  [2] = '{`TEC_ADDR_CMP0, `TEC_ADDR_CMP1};

  // map a clock select code to a divide exponent for one channel
  function automatic int unsigned div_exp(input int unsigned ch, input logic [2:0] code);
    int unsigned e;
    e = 0;
    case (code)
      3'h2: e = (ch == 0) ? `TEC_CH0_EXP2 : `TEC_CH1_EXP2;
      3'h3: e = (ch == 0) ? `TEC_CH0_EXP3 : `TEC_CH1_EXP3;
      3'h4: e = (ch == 0) ? `TEC_CH0_EXP4 : `TEC_CH1_EXP4;
      3'h5: e = (ch == 0) ? `TEC_CH0_EXP5 : `TEC_CH1_EXP5;
      3'h6: e = (ch == 0) ? `TEC_CH0_EXP6 : `TEC_CH1_EXP6;
      3'h7: e = (ch == 0) ? CH0_SLOW_EXP : CH1_SLOW_EXP;
      default: e = 0;
    endcase
    if (e > PRESCALE_W)
      e = PRESCALE_W;
    return e;
  endfunction

  // shared-pin direction bits
  logic [7:0] port1_dir_reg, port1_dir_next;  // port 1 direction
  logic [3:0] port3_dir_reg, port3_dir_next;  // port 3 direction, low nibble
  logic [1:0] pin_dir;                        // per-channel pin direction
  // read path
  tec_byte_t  rdata_next;                     // read data next
  logic       rvalid_next;                    // read answer next
  // per-channel read views
  tec_byte_t  ch_mode_rd [2];                 // mode control as read
  tec_byte_t  ch_sel_rd  [2];                 // clock select as read
  tec_byte_t  ch_cmp_rd  [2];                 // compare value as read

  // prescaler tick bundle
  tec_tick_if #(.W(PRESCALE_W)) ticks ();

  // one shared divider for both channels
  tec_prescaler #(
    .DIV_W   (PRESCALE_W)
  ) u_prescaler (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ticks   (ticks)
  );

  // each timer pin follows its direction bit
  assign pin_dir[0] = port1_dir_reg[`TEC_PIN_BIT_T0];
  assign pin_dir[1] = port3_dir_reg[`TEC_PIN_BIT_T1];

  // direction register writes
  always_comb
  begin
    port1_dir_next = port1_dir_reg;
    port3_dir_next = port3_dir_reg;
    if (reg_wr && reg_addr == `TEC_ADDR_PORT1_DIR)
      port1_dir_next = reg_wdata;
    if (reg_wr && reg_addr == `TEC_ADDR_PORT3_DIR)
      port3_dir_next = reg_wdata[3:0];
  end

  // direction registers start as inputs
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port1_dir_reg <= `TEC_RST_PORT_DIR;
      port3_dir_reg <= 4'(`TEC_RST_PORT_DIR);
    end
    else
    begin
      port1_dir_reg <= port1_dir_next;
      port3_dir_reg <= port3_dir_next;
    end
  end

  // mirror direction registers onto the port outputs
  assign port1_dir_out = port1_dir_reg;
  assign port3_dir_out = port3_dir_reg;

  // read decode; unmapped addresses read zero
  always_comb
  begin
    rdata_next  = 8'h00;
    rvalid_next = reg_rd;
    if (!reg_rd)
      rdata_next = 8'h00;
    else if (reg_addr == `TEC_ADDR_PORT1_DIR)
      rdata_next = port1_dir_reg;
    else if (reg_addr == `TEC_ADDR_PORT3_DIR)
      rdata_next = `TEC_PORT3_FIXED | {4'h0, port3_dir_reg};
    else if (reg_addr == MODE_ADDR[0])
      rdata_next = ch_mode_rd[0];
    else if (reg_addr == MODE_ADDR[1])
      rdata_next = ch_mode_rd[1];
    else if (reg_addr == SEL_ADDR[0])
      rdata_next = ch_sel_rd[0];
    else if (reg_addr == SEL_ADDR[1])
      rdata_next = ch_sel_rd[1];
    else if (reg_addr == CMP_ADDR[0])
      rdata_next = ch_cmp_rd[0];
    else if (reg_addr == CMP_ADDR[1])
      rdata_next = ch_cmp_rd[1];
    else
      rdata_next = 8'h00;
  end

  // register the read answer
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rdata  <= rdata_next;
      reg_rvalid <= rvalid_next;
    end
  end

  // one timer per channel, alike except for the per-channel clock select divides
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_ch
      tec_mode_t  mode_reg, mode_next;      // stored mode control
      logic [2:0] sel_reg, sel_next;        // count clock select
      tec_byte_t  cmp_reg, cmp_next;        // compare value
      tec_byte_t  cnt_reg, cnt_next;        // count register
      logic       tff_reg, tff_next;        // timer output flip-flop
      logic       act_reg, act_next;        // PWM active phase
      logic       irq_next;                 // match request next
      logic       out_next, oe_n_next;      // pin drive next
      logic       wr_mode, wr_sel, wr_cmp;  // register write strobes
      logic       preset_hi, preset_lo;     // preset requests
      logic       ev_rise, ev_fall;         // synchronised pin edges
      logic       cnt_tick;                 // selected count enable
      logic       match;                    // counter equals compare
      tec_byte_t  cnt_inc;                  // counter plus one

      // pin edges pass the synchroniser first
      tec_edge_sync u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pin_in  (timer_pin_in[ch]),
        .rise    (ev_rise),
        .fall    (ev_fall)
      );

      // write strobes for this channel
      assign wr_mode = reg_wr && (reg_addr == MODE_ADDR[ch]);
      assign wr_sel  = reg_wr && (reg_addr == SEL_ADDR[ch]);
      assign wr_cmp  = reg_wr && (reg_addr == CMP_ADDR[ch]);

      // presets need exactly one bit set and match-clear mode in the written value
      assign preset_hi = wr_mode && reg_wdata[`TEC_BIT_PRESET_SET]
                         && !reg_wdata[`TEC_BIT_PRESET_CLR]
                         && !reg_wdata[`TEC_BIT_PWM_SEL];
      assign preset_lo = wr_mode && reg_wdata[`TEC_BIT_PRESET_CLR]
                         && !reg_wdata[`TEC_BIT_PRESET_SET]
                         && !reg_wdata[`TEC_BIT_PWM_SEL];

      // count enable: an edge of the pin, or a prescaler tap
      always_comb
      begin
        if (sel_reg == `TEC_SEL_FALL)
          cnt_tick = ev_fall;
        else if (sel_reg == `TEC_SEL_RISE)
          cnt_tick = ev_rise;
        else
          cnt_tick = ticks.tick[div_exp(ch, sel_reg)];
      end

      assign match   = (cnt_reg == cmp_reg);
      assign cnt_inc = cnt_reg + 8'h01;

      // register contents, counter, output flip-flops
      always_comb
      begin
        mode_next = mode_reg;
        sel_next  = sel_reg;
        cmp_next  = cmp_reg;
        cnt_next  = cnt_reg;
        tff_next  = tff_reg;
        act_next  = act_reg;
        irq_next  = 1'b0;
        // software writes
        if (wr_mode)
        begin
          mode_next.count_en        = reg_wdata[`TEC_BIT_COUNT_EN];
          mode_next.pwm_sel         = reg_wdata[`TEC_BIT_PWM_SEL];
          mode_next.invert_or_level = reg_wdata[`TEC_BIT_INV_LVL];
          mode_next.out_en          = reg_wdata[`TEC_BIT_OUT_EN];
        end
        if (wr_sel)
          sel_next = reg_wdata[2:0];
        if (wr_cmp)
          cmp_next = reg_wdata;
        // counting
        if (!mode_reg.count_en)
        begin
          cnt_next = 8'h00;
          act_next = 1'b0;
        end
        else if (cnt_tick)
        begin
          if (mode_reg.pwm_sel)
          begin
            // free running; overflow opens the active phase, match closes it
            cnt_next = cnt_inc;
            if (cnt_reg == 8'hff)
              act_next = 1'b1;
            if (cnt_inc == cmp_reg)
              act_next = 1'b0;
          end
          else if (match)
          begin
            // match restarts from zero so the period is compare plus one
            cnt_next = 8'h00;
            irq_next = 1'b1;
            if (mode_reg.invert_or_level)
              tff_next = ~tff_reg;
          end
          else
            cnt_next = cnt_inc;
        end
        // presets act whether counting or not
        if (preset_hi)
          tff_next = 1'b1;
        else if (preset_lo)
          tff_next = 1'b0;
      end

      // timer output and pin drive from the present settings
      always_comb
      begin
        if (!mode_reg.out_en)
          out_next = 1'b0;
        else if (mode_reg.pwm_sel)
          out_next = (act_reg & mode_reg.count_en) ^ mode_reg.invert_or_level;
        else
          out_next = tff_reg;
        oe_n_next = pin_dir[ch];
      end

      // register this channel's state
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          mode_reg            <= tec_mode_t'(4'h0);
          sel_reg             <= `TEC_RST_CLKSEL;
          cmp_reg             <= `TEC_RST_CMP;
          cnt_reg             <= 8'h00;
          tff_reg             <= 1'b0;
          act_reg             <= 1'b0;
          match_irq[ch]       <= 1'b0;
          timer_pin_out[ch]   <= 1'b0;
          timer_pin_oe_n[ch]  <= 1'b1;
        end
        else
        begin
          mode_reg            <= mode_next;
          sel_reg             <= sel_next;
          cmp_reg             <= cmp_next;
          cnt_reg             <= cnt_next;
          tff_reg             <= tff_next;
          act_reg             <= act_next;
          match_irq[ch]       <= irq_next;
          timer_pin_out[ch]   <= out_next;
          timer_pin_oe_n[ch]  <= oe_n_next;
        end
      end

      // read views; preset positions and bits five and four read zero
      always_comb
      begin
        ch_mode_rd[ch]                     = 8'h00;
        ch_mode_rd[ch][`TEC_BIT_COUNT_EN]  = mode_reg.count_en;
        ch_mode_rd[ch][`TEC_BIT_PWM_SEL]   = mode_reg.pwm_sel;
        ch_mode_rd[ch][`TEC_BIT_INV_LVL]   = mode_reg.invert_or_level;
        ch_mode_rd[ch][`TEC_BIT_OUT_EN]    = mode_reg.out_en;
        ch_sel_rd[ch]                      = {5'h00, sel_reg};
        ch_cmp_rd[ch]                      = cmp_reg;
      end
    end
  endgenerate

endmodule

`default_nettype wire

// [inc/tec_cfg.svh]
// offsets, field positions, reset values and clock-select codes of the
// dual 8-bit timer/event counter.
// assumes byte addresses on a 16-bit peripheral address space.
`ifndef TEC_CFG_SVH
`define TEC_CFG_SVH

// register byte addresses
`define TEC_ADDR_PORT1_DIR   16'hff21
`define TEC_ADDR_PORT3_DIR   16'hff23
`define TEC_ADDR_MODE1       16'hff43
`define TEC_ADDR_MODE0       16'hff6b
`define TEC_ADDR_CLKSEL0     16'hff6a
`define TEC_ADDR_CLKSEL1     16'hff8c
`define TEC_ADDR_CMP0        16'hff70
`define TEC_ADDR_CMP1        16'hff71

// mode control field positions
`define TEC_BIT_COUNT_EN     7
`define TEC_BIT_PWM_SEL      6
`define TEC_BIT_PRESET_SET   3
`define TEC_BIT_PRESET_CLR   2
`define TEC_BIT_INV_LVL      1
`define TEC_BIT_OUT_EN       0

// reset values
`define TEC_RST_MODE         8'h00
`define TEC_RST_PORT_DIR     8'hff
`define TEC_RST_CLKSEL       3'h0
`define TEC_RST_CMP          8'h00

// port 3 upper nibble is fixed at ones
`define TEC_PORT3_FIXED      8'hf0
// shared pin positions in the direction registers
`define TEC_PIN_BIT_T0       7
`define TEC_PIN_BIT_T1       3

// clock select codes for the external edge
`define TEC_SEL_FALL         3'h0
`define TEC_SEL_RISE         3'h1

// prescaler exponents per channel, codes 2 to 7
`define TEC_CH0_EXP2         0
`define TEC_CH0_EXP3         1
`define TEC_CH0_EXP4         2
`define TEC_CH0_EXP5         6
`define TEC_CH0_EXP6         8
`define TEC_CH0_EXP7         13
`define TEC_CH1_EXP2         0
`define TEC_CH1_EXP3         1
`define TEC_CH1_EXP4         4
`define TEC_CH1_EXP5         6
`define TEC_CH1_EXP6         8
`define TEC_CH1_EXP7         12

`endif

// [inc/tec_pkg.sv]
// types shared by the timer/event counter modules.
// assumes nothing beyond a single clock domain.
package tec_pkg;

  typedef logic [7:0]  tec_byte_t;   // register data
  typedef logic [15:0] tec_addr_t;   // register byte address

  // stored mode control bits; the preset bits are not stored
  typedef struct packed
  {
    logic count_en;
    logic pwm_sel;
    logic invert_or_level;
    logic out_en;
  } tec_mode_t;

endpackage

// [inc/tec_tick_if.sv]
// prescaler tick bundle: one enable pulse per power-of-two divide.
// assumes the producer and consumers share ref_clk.
`timescale 1ns/1ps
`default_nettype none

interface tec_tick_if #(
  parameter int unsigned W = 13
);
  logic [W:0] tick;  // tick[k] pulses once every 2**k clocks

  modport src (output tick);
  modport dst (input  tick);
endinterface

`default_nettype wire

// [src/tec_prescaler.sv]
// free-running divider giving one-cycle enables at ref_clk / 2**k.
// assumes a single clock and async active-low reset.
`timescale 1ns/1ps
`default_nettype none

module tec_prescaler #(
  parameter int unsigned DIV_W = 13
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // tick bundle
  tec_tick_if.src   ticks
);
  import tec_pkg::*;

  logic [DIV_W-1:0] div_reg;   // divider state
  logic [DIV_W-1:0] div_next;  // divider next value

  // next divider value, wraps freely
  always_comb
  begin
    div_next = DIV_W'(div_reg + 1'b1);
  end

  // register the divider
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_reg <= '0;
    else
      div_reg <= div_next;
  end

  // undivided rate always enabled
  assign ticks.tick[0] = 1'b1;

  // tick k fires when the low k divider bits are all ones
  genvar k;
  generate
    for (k = 1; k <= DIV_W; k++)
    begin : g_tap
      assign ticks.tick[k] = &div_reg[k-1:0];
    end
  endgenerate

endmodule

`default_nettype wire

// [src/tec_edge_sync.sv]
// three-stage synchroniser with agreement filter and edge pulses.
// assumes the pin is asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none

module tec_edge_sync (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // raw pin
  input  wire logic pin_in,
  // filtered edges, one cycle each
  output logic      rise,
  output logic      fall
);
  import tec_pkg::*;

  logic s1_reg, s2_reg, s3_reg;   // synchroniser chain
  logic stable_reg, stable_next;  // accepted level
  logic rise_next, fall_next;     // edge pulses next

  // accept a level only once stages two and three agree
  always_comb
  begin
    stable_next = (s2_reg == s3_reg) ? s3_reg : stable_reg;
    rise_next   = stable_next & ~stable_reg;
    fall_next   = ~stable_next & stable_reg;
  end

  // register chain and pulses
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg     <= 1'b0;
      s2_reg     <= 1'b0;
      s3_reg     <= 1'b0;
      stable_reg <= 1'b0;
      rise       <= 1'b0;
      fall       <= 1'b0;
    end
    else
    begin
      s1_reg     <= pin_in;
      s2_reg     <= s1_reg;
      s3_reg     <= s2_reg;
      stable_reg <= stable_next;
      rise       <= rise_next;
      fall       <= fall_next;
    end
  end

endmodule

`default_nettype wire

// [tb/tec_checker.sv]
// concurrent checks on the ports of the dual timer/event counter.
// assumes it is bound to tec_top and shares its ref_clk and rst_n.
`include "tec_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tec_checker #(
  parameter int unsigned PRESCALE_W   = 13,
  parameter int unsigned CH0_SLOW_EXP = `TEC_CH0_EXP7,
  parameter int unsigned CH1_SLOW_EXP = `TEC_CH1_EXP7
) (
  // clock and reset
  input wire logic               ref_clk,
  input wire logic               rst_n,
  // register port
  input wire tec_pkg::tec_addr_t reg_addr,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire tec_pkg::tec_byte_t reg_wdata,
  input wire tec_pkg::tec_byte_t reg_rdata,
  input wire logic               reg_rvalid,
  // pins and requests
  input wire logic [1:0]         timer_pin_in,
  input wire logic [1:0]         timer_pin_out,
  input wire logic [1:0]         timer_pin_oe_n,
  input wire logic [7:0]         port1_dir_out,
  input wire logic [3:0]         port3_dir_out,
  input wire logic [1:0]         match_irq
);
  import tec_pkg::*;
  logic [1:0] oe_reg, ce_reg, pwm_reg;  // written enable, run and mode bits
  logic [7:0] cmp0_reg;                 // written channel 0 compare
  logic [2:0] cs0_reg;                  // written channel 0 clock select
  logic [8:0] gap0_reg;                 // clocks since last channel 0 request
  logic       vld0_reg;                 // gap spans requests with no write between
  logic       wr0, wr1;                 // mode register writes
  assign wr0 = reg_wr && reg_addr == `TEC_ADDR_MODE0;
  assign wr1 = reg_wr && reg_addr == `TEC_ADDR_MODE1;

  // mirror what software wrote and time the requests
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {oe_reg, ce_reg, pwm_reg} <= 6'h00;
      {cmp0_reg, cs0_reg, gap0_reg, vld0_reg} <= 21'h000000;
    end
    else
    begin
      if (wr0) {ce_reg[0], pwm_reg[0], oe_reg[0]} <= {reg_wdata[7:6], reg_wdata[0]};
      if (wr1) {ce_reg[1], pwm_reg[1], oe_reg[1]} <= {reg_wdata[7:6], reg_wdata[0]};
      if (reg_wr && reg_addr == `TEC_ADDR_CMP0) cmp0_reg <= reg_wdata;
      if (reg_wr && reg_addr == `TEC_ADDR_CLKSEL0) cs0_reg <= reg_wdata[2:0];
      gap0_reg <= match_irq[0] ? 9'h001 : gap0_reg + 9'h001;
      vld0_reg <= reg_wr ? 1'b0 : (match_irq[0] | vld0_reg);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // a preset or pwm write to channel 0, then a quiet cycle
  sequence s_preset_then_quiet;
    wr0 && reg_wdata[7:6] == 2'b00 && reg_wdata[0] && ^reg_wdata[3:2] ##1 !wr0;
  endsequence
  sequence s_pwm_then_quiet;
    wr0 && reg_wdata[7:6] == 2'b01 && reg_wdata[0] ##1 !wr0;
  endsequence

  property p_dir_to_oe;
    timer_pin_oe_n == {$past(port3_dir_out[3]), $past(port1_dir_out[7])};
  endproperty
  property p_preset;
    s_preset_then_quiet |=> timer_pin_out[0] == $past(reg_wdata[3], 2);
  endproperty
  property p_pwm_idle;
    s_pwm_then_quiet |=> timer_pin_out[0] == $past(reg_wdata[1], 2);
  endproperty
  property p_out_gate;
    (~$past(oe_reg) & timer_pin_out) == 2'h0;
  endproperty
  property p_irq_needs_run;
    (match_irq & ~($past(ce_reg) & ~$past(pwm_reg))) == 2'h0;
  endproperty
  property p_period;
    match_irq[0] && vld0_reg && cs0_reg == 3'h2 |-> gap0_reg == {1'b0, cmp0_reg} + 9'h001;
  endproperty
  property p_preset_reads_zero;
    reg_rd && (reg_addr == `TEC_ADDR_MODE0 || reg_addr == `TEC_ADDR_MODE1)
      |=> reg_rvalid && reg_rdata[5:2] == 4'h0;
  endproperty
  property p_irq_pulse;
    (match_irq & $past(match_irq)) == 2'h0;
  endproperty

  a_dir_to_oe: assert property (p_dir_to_oe)
    else $error("pin enable does not follow direction bit");
  a_preset: assert property (p_preset)
    else $error("preset did not reach the pin");
  a_pwm_idle: assert property (p_pwm_idle)
    else $error("stopped pwm pin not at inactive level");
  a_out_gate: assert property (p_out_gate)
    else $error("pin high while output disabled");
  a_irq_needs_run: assert property (p_irq_needs_run)
    else $error("request while stopped or in pwm mode");
  a_period: assert property (p_period)
    else $error("interval period wrong");
  a_preset_reads_zero: assert property (p_preset_reads_zero)
    else $error("preset bits read nonzero");
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("request longer than one cycle");
endmodule

bind tec_top tec_checker #(.PRESCALE_W(PRESCALE_W), .CH0_SLOW_EXP(CH0_SLOW_EXP),
  .CH1_SLOW_EXP(CH1_SLOW_EXP)) u_tec_checker (.ref_clk(ref_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .timer_pin_in(timer_pin_in),
  .timer_pin_out(timer_pin_out), .timer_pin_oe_n(timer_pin_oe_n),
  .port1_dir_out(port1_dir_out), .port3_dir_out(port3_dir_out), .match_irq(match_irq));

`default_nettype wire

// [tb/tec_pin_model.sv]
// far side of the shared timer pins: an external event source.
// assumes oe_n is active low and the bench calls pulse().
`timescale 1ns/1ps
`default_nettype none

module tec_pin_model (
  // design pin side
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] oe_n,
  // resolved pin level
  output logic [1:0]      pin_wire
);
  logic [1:0] src = 2'h0;  // external source level

  // the design owns the pin while driving, the source otherwise
  assign pin_wire = (oe_n & src) | (~oe_n & pin_out);

  // whole pulses, wider than the input filter, off the clock grid
  task automatic pulse(input int ch, input int n);
    repeat (n)
    begin
      src[ch] = 1'b1;
      #53;
      src[ch] = 1'b0;
      #57;
    end
  endtask
endmodule

`default_nettype wire

// [tb/tec_top_bench.sv]
// self-checking bench for the dual timer/event counter.
// assumes tec_top, tec_pin_model and the bound checker are compiled.
`include "tec_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: %s", $time, m); end end

module tec_top_bench;
  import tec_pkg::*;
  logic       ref_clk = 1'b0;            // 100 MHz clock
  logic       rst_n = 1'b0;              // reset, held at start
  tec_addr_t  reg_addr = 16'h0000;       // register port drive
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  tec_byte_t  reg_wdata = 8'h00;
  tec_byte_t  reg_rdata;                 // design outputs
  logic       reg_rvalid;
  logic [1:0] pin_wire, timer_pin_out, timer_pin_oe_n, match_irq;
  logic [7:0] port1_dir_out;
  logic [3:0] port3_dir_out;
  int         err_count = 0;
  int         n_compared = 0;
  int         seed = 77832;
  int         cyc = 0, ni0 = 0, ni1 = 0, last0 = 0, per0 = 0;
  logic       pl0 = 1'b0, pp0 = 1'b0;    // pin at the last two requests
  tec_byte_t  exp_q [$];                 // expected read data
  // mode writes and pin levels expected after each
  tec_byte_t  td [15] = '{8'h01, 8'h09, 8'h01, 8'h05, 8'h09, 8'h08, 8'h00, 8'h01,
                          8'h00, 8'h40, 8'h42, 8'h43, 8'h47, 8'h41, 8'h49};
  localparam logic [14:0] TP = 15'h1896;
  int         ex [3] = '{`TEC_CH0_EXP2, `TEC_CH0_EXP3, `TEC_CH0_EXP4};

  always #5 ref_clk = ~ref_clk;

  tec_top u_tec_top (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .timer_pin_in(pin_wire), .timer_pin_out(timer_pin_out),
    .timer_pin_oe_n(timer_pin_oe_n), .port1_dir_out(port1_dir_out),
    .port3_dir_out(port3_dir_out), .match_irq(match_irq));
  tec_pin_model u_tec_pin_model (.pin_out(timer_pin_out), .oe_n(timer_pin_oe_n),
    .pin_wire(pin_wire));

  // watch answers and requests
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (reg_rvalid === 1'b1)
      `CHK(reg_rdata, exp_q.pop_front(), "read data")
    if (match_irq[0] === 1'b1)
    begin
      per0 <= cyc - last0;
      last0 <= cyc;
      ni0 <= ni0 + 1;
      pl0 <= timer_pin_out[0];
      pp0 <= pl0;
    end
    if (match_irq[1] === 1'b1) ni1 <= ni1 + 1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input tec_addr_t a, input tec_byte_t d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input tec_addr_t a, input tec_byte_t e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // cut a hang short
  initial
  begin
    #200000;
    err_count++;
    test_done;
  end

  // main sequence
  initial
  begin
    tec_byte_t d;
    int        cmp, base, hi;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(1);
    `CHK(port1_dir_out, 8'hff, "port1 direction reset")
    `CHK(port3_dir_out, 4'hf, "port3 direction reset")
    `CHK(timer_pin_oe_n, 2'h3, "pins released")
    rd(`TEC_ADDR_PORT1_DIR, 8'hff);
    rd(`TEC_ADDR_PORT3_DIR, 8'hff);
    rd(`TEC_ADDR_MODE0, 8'h00);
    rd(`TEC_ADDR_MODE1, 8'h00);
    rd(16'hff00, 8'h00);
    $display("test reset values done");
    for (int ch = 0; ch < 2; ch++)
    begin
      d = 8'($random(seed)) & 8'h77;
      wr(ch ? `TEC_ADDR_MODE1 : `TEC_ADDR_MODE0, d);
      rd(ch ? `TEC_ADDR_MODE1 : `TEC_ADDR_MODE0, d & 8'hc3);
      wr(ch ? `TEC_ADDR_MODE1 : `TEC_ADDR_MODE0, 8'h00);
    end
    d = 8'($random(seed));
    wr(`TEC_ADDR_PORT3_DIR, d);
    rd(`TEC_ADDR_PORT3_DIR, d | `TEC_PORT3_FIXED);
    wr(`TEC_ADDR_PORT1_DIR, 8'h7f);
    wr(`TEC_ADDR_PORT3_DIR, 8'hf7);
    tick(2);
    `CHK(timer_pin_oe_n, 2'h0, "pins driving")
    $display("test readback and direction done");
    for (int ch = 0; ch < 2; ch++)
    begin
      for (int i = 0; i < 15; i++)
      begin
        wr(ch ? `TEC_ADDR_MODE1 : `TEC_ADDR_MODE0, td[i]);
        tick(2);
        `CHK(timer_pin_out[ch], TP[i], "pin level")
      end
      wr(ch ? `TEC_ADDR_MODE1 : `TEC_ADDR_MODE0, 8'h00);
    end
    $display("test output control done");
    for (int k = 0; k < 3; k++)
    begin
      cmp = ($random(seed) & 15) + 1;
      wr(`TEC_ADDR_CLKSEL0, 8'(k + 2));
      wr(`TEC_ADDR_CMP0, 8'(cmp));
      wr(`TEC_ADDR_MODE0, 8'h02);
      wr(`TEC_ADDR_MODE0, 8'h03);
      wr(`TEC_ADDR_MODE0, 8'h07);
      base = ni0;
      wr(`TEC_ADDR_MODE0, 8'h83);
      for (int t = 0; t < 3000 && ni0 < base + 3; t++) tick(1);
      `CHK(ni0, base + 3, "interval requests")
      `CHK(per0, (cmp + 1) << ex[k], "interval period")
      `CHK(pl0 ^ pp0, 1'b1, "toggle on match")
      wr(`TEC_ADDR_MODE0, 8'h03);
      tick(2);
      base = ni0;
      tick(40);
      `CHK(ni0, base, "request while stopped")
    end
    $display("test interval done");
    wr(`TEC_ADDR_CLKSEL0, 8'h02);
    cmp = ($random(seed) & 127) + 1;
    wr(`TEC_ADDR_CMP0, 8'(cmp));
    wr(`TEC_ADDR_MODE0, 8'h40);
    wr(`TEC_ADDR_MODE0, 8'h41);
    base = ni0;
    wr(`TEC_ADDR_MODE0, 8'hc1);
    tick(300);
    hi = 0;
    for (int t = 0; t < 512; t++)
    begin
      tick(1);
      hi += timer_pin_out[0];
    end
    `CHK(hi, 2 * cmp, "pwm active width")
    `CHK(ni0, base, "request in pwm mode")
    wr(`TEC_ADDR_MODE0, 8'h41);
    tick(2);
    `CHK(timer_pin_out[0], 1'b0, "pwm stopped level")
    $display("test pwm done");
    wr(`TEC_ADDR_PORT3_DIR, 8'hff);
    wr(`TEC_ADDR_CMP1, 8'h04);
    for (int s = 1; s >= 0; s--)
    begin
      wr(`TEC_ADDR_CLKSEL1, 8'(s));
      wr(`TEC_ADDR_MODE1, 8'h80);
      tick(2);
      base = ni1;
      u_tec_pin_model.pulse(1, 4);
      tick(10);
      `CHK(ni1, base, "early event match")
      u_tec_pin_model.pulse(1, 1);
      tick(10);
      `CHK(ni1, base + 1, "event match")
      wr(`TEC_ADDR_MODE1, 8'h00);
    end
    $display("test event counting done");
    test_done;
  end
endmodule

`default_nettype wire
